/* ivtm_pkg.sv */
package ivtm_pkg;

  localparam int NSRC  = 56;
  localparam int NTRAP = 8;
  localparam int IDXW  = 6;

  // one source control word, low byte of the register
  typedef struct packed {
    logic       ir;
    logic       ie;
    logic [3:0] priority_level_field;
    logic [1:0] group_level_field;
  } ivtm_ctrl_s;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ivtm_bus_s;

  localparam ivtm_ctrl_s CTRL_RESET = 8'h00;

  // register map, word addresses on the plain port
  localparam logic [7:0] ADDR_CTRL_LAST = 8'h37;
  localparam logic [7:0] ADDR_TRAP_FLAG = 8'h40;
  localparam logic [7:0] ADDR_EV_STATUS = 8'h41;
  localparam logic [7:0] ADDR_EV_CLEAR  = 8'h42;
  localparam logic [7:0] ADDR_EV_ENABLE = 8'h43;
  localparam logic [7:0] ADDR_SVC_STATE = 8'h44;

  // trap flag bit positions; 0..2 class a, 3..7 class b
  localparam int TF_NMI    = 0;
  localparam int TF_STKOF  = 1;
  localparam int TF_STKUF  = 2;
  localparam int TF_UNDOPC = 3;
  localparam int TF_PRTFLT = 4;
  localparam int TF_ILLOPA = 5;
  localparam int TF_ILLINA = 6;
  localparam int TF_ILLBUS = 7;
  localparam logic [7:0] TF_CLASS_A = 8'h07;
  localparam logic [7:0] TF_CLASS_B = 8'hf8;
  localparam logic [7:0] TF_RESET   = 8'h00;

  localparam logic [6:0] TRAPNUM_NMI   = 7'h02;
  localparam logic [6:0] TRAPNUM_STKOF = 7'h04;
  localparam logic [6:0] TRAPNUM_STKUF = 7'h06;
  localparam logic [6:0] TRAPNUM_B     = 7'h0a;

  // event status bits
  localparam int EV_TRAP_TAKEN = 0;
  localparam int EV_INT_TAKEN  = 1;
  localparam int EVW           = 2;

  // source index ranges and trap number bases
  localparam logic [6:0] TN_CC_LO   = 7'h10;
  localparam logic [6:0] TN_CC_MID  = 7'h30;
  localparam logic [6:0] TN_CC_HI   = 7'h44;
  localparam logic [6:0] TN_TIMERS  = 7'h20;
  localparam logic [6:0] TN_T7      = 7'h3d;
  localparam logic [6:0] TN_EXT     = 7'h40;
  localparam logic [6:0] TN_TXBUF   = 7'h47;

  // sources: 0-31 capture compare channels, 32-33 their timers 0/1, 34-47 timers 2-6,
  // capture reload, conversion done/overrun, async tx/rx/err, sync tx/rx/err,
  // 48-49 capture compare timers 7/8, 50 pwm, 51-54 ext periph 0-3, 55 async tx buffer
  function automatic logic [6:0] ivtm_trap_num(input logic [IDXW-1:0] i);
    logic [6:0] n;
    n = {1'b0, i};
    if (i < 6'd16) begin
      ivtm_trap_num = TN_CC_LO + n;
    end else if (i < 6'd29) begin
      ivtm_trap_num = TN_CC_MID + n - 7'd16;
    end else if (i < 6'd32) begin
      ivtm_trap_num = TN_CC_HI + n - 7'd29;
    end else if (i < 6'd48) begin
      ivtm_trap_num = TN_TIMERS + n - 7'd32;
    end else if (i < 6'd51) begin
      ivtm_trap_num = TN_T7 + n - 7'd48;
    end else if (i < 6'd55) begin
      ivtm_trap_num = TN_EXT + n - 7'd51;
    end else begin
      ivtm_trap_num = TN_TXBUF;
    end
  endfunction : ivtm_trap_num

  function automatic logic [15:0] ivtm_vec_addr(input logic [6:0] num);
    ivtm_vec_addr = {7'h00, num, 2'b00};
  endfunction : ivtm_vec_addr

endpackage : ivtm_pkg

/* ivtm_arbiter.sv */
`timescale 1ns/1ps
module ivtm_arbiter (
  input  ivtm_pkg::ivtm_ctrl_s [ivtm_pkg::NSRC-1:0] ctrl,
  output logic                                      win_valid,
  output logic [ivtm_pkg::IDXW-1:0]                 win_idx,
  output logic [3:0]                                win_lvl
);

  logic [5:0] best_key;
  logic [5:0] cand_key;

  always_comb begin
    win_valid = 1'b0;
    win_idx   = '0;
    best_key  = 6'h00;
    cand_key  = 6'h00;
    for (int i = 0; i < ivtm_pkg::NSRC; i++) begin
      cand_key = {ctrl[i].priority_level_field, ctrl[i].group_level_field};
      if (ctrl[i].ir && ctrl[i].ie) begin
        // strict compare keeps the lower index on a full tie
        if (!win_valid || cand_key > best_key) begin
          win_valid = 1'b1;
          win_idx   = i[ivtm_pkg::IDXW-1:0];
          best_key  = cand_key;
        end
      end
    end
    win_lvl = best_key[5:2];
  end

endmodule : ivtm_arbiter

/* ivtm_trap_select.sv */
`timescale 1ns/1ps
module ivtm_trap_select (
  input  logic [ivtm_pkg::NTRAP-1:0] pend,
  input  logic                       busy_a,
  input  logic                       busy_b,
  output logic                       valid,
  output logic                       cls_a,
  output logic [ivtm_pkg::NTRAP-1:0] sel,
  output logic [6:0]                 num
);

  always_comb begin
    valid = 1'b0;
    cls_a = 1'b0;
    sel   = '0;
    num   = 7'h00;
    // class a preempts class b, blocked only by a class a in service
    if (|(pend & ivtm_pkg::TF_CLASS_A) && !busy_a) begin
      valid = 1'b1;
      cls_a = 1'b1;
      if (pend[ivtm_pkg::TF_NMI]) begin
        sel[ivtm_pkg::TF_NMI] = 1'b1;
        num = ivtm_pkg::TRAPNUM_NMI;
      end else if (pend[ivtm_pkg::TF_STKOF]) begin
        sel[ivtm_pkg::TF_STKOF] = 1'b1;
        num = ivtm_pkg::TRAPNUM_STKOF;
      end else begin
        sel[ivtm_pkg::TF_STKUF] = 1'b1;
        num = ivtm_pkg::TRAPNUM_STKUF;
      end
    end else if (|(pend & ivtm_pkg::TF_CLASS_B) && !busy_a && !busy_b) begin
      // all class b conditions share one vector and are taken together
      valid = 1'b1;
      sel   = pend & ivtm_pkg::TF_CLASS_B;
      num   = ivtm_pkg::TRAPNUM_B;
    end
  end

endmodule : ivtm_trap_select

/* ivtm_core.sv */
`timescale 1ns/1ps
module ivtm_core (
  input  logic                        clk,
  input  logic                        reset,
  input  ivtm_pkg::ivtm_bus_s         bus,
  output logic [15:0]                 rdata_q,
  input  logic [ivtm_pkg::NSRC-1:0]   src_req,
  input  logic [ivtm_pkg::NTRAP-1:0]  trap_evt,
  input  logic [3:0]                  cpu_level,
  input  logic                        vec_ack,
  input  logic                        trap_done,
  output logic                        vec_valid_q,
  output logic                        vec_is_trap_q,
  output logic [6:0]                  vec_num_q,
  output logic [15:0]                 vec_addr_q,
  output logic                        xfer_ok_q,
  output logic                        irq_q
);

  ivtm_pkg::ivtm_ctrl_s [ivtm_pkg::NSRC-1:0] ctrl_q;
  ivtm_pkg::ivtm_ctrl_s [ivtm_pkg::NSRC-1:0] ctrl_d;
  logic [ivtm_pkg::NTRAP-1:0]                tflag_q;
  logic [ivtm_pkg::NTRAP-1:0]                tflag_d;
  logic [ivtm_pkg::NTRAP-1:0]                tpend_q;
  logic [ivtm_pkg::NTRAP-1:0]                tpend_d;
  logic                                      busy_a_q;
  logic                                      busy_a_d;
  logic                                      busy_b_q;
  logic                                      busy_b_d;
  logic [ivtm_pkg::EVW-1:0]                  ev_st_q;
  logic [ivtm_pkg::EVW-1:0]                  ev_st_d;
  logic [ivtm_pkg::EVW-1:0]                  ev_en_q;
  logic [ivtm_pkg::EVW-1:0]                  ev_en_d;
  logic                                      irq_d;
  logic [15:0]                               rdata_d;
  logic                                      vec_valid_d;
  logic                                      vec_is_trap_d;
  logic [6:0]                                vec_num_d;
  logic [15:0]                               vec_addr_d;
  logic                                      xfer_ok_d;
  logic                                      off_cls_a_q;
  logic                                      off_cls_a_d;
  logic [ivtm_pkg::NTRAP-1:0]                off_sel_q;
  logic [ivtm_pkg::NTRAP-1:0]                off_sel_d;
  logic [ivtm_pkg::IDXW-1:0]                 off_src_q;
  logic [ivtm_pkg::IDXW-1:0]                 off_src_d;

  logic                                      win_valid;
  logic [ivtm_pkg::IDXW-1:0]                 win_idx;
  logic [3:0]                                win_lvl;
  logic                                      tr_valid;
  logic                                      tr_cls_a;
  logic [ivtm_pkg::NTRAP-1:0]                tr_sel;
  logic [6:0]                                tr_num;
  logic                                      ack_trap;
  logic                                      ack_int;
  logic                                      wr_ctrl;

  ivtm_arbiter u_arb (
    .ctrl      (ctrl_q),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_lvl   (win_lvl)
  );

  ivtm_trap_select u_trap (
    .pend   (tpend_q),
    .busy_a (busy_a_q),
    .busy_b (busy_b_q),
    .valid  (tr_valid),
    .cls_a  (tr_cls_a),
    .sel    (tr_sel),
    .num    (tr_num)
  );

  // an ack applies to the offer standing in the same cycle
  assign ack_trap = vec_ack && vec_valid_q && vec_is_trap_q;
  assign ack_int  = vec_ack && vec_valid_q && !vec_is_trap_q;
  assign wr_ctrl  = bus.we && (bus.addr <= ivtm_pkg::ADDR_CTRL_LAST);

  // one decode for every single-address register write
  function automatic logic wr_hit(input ivtm_pkg::ivtm_bus_s b, input logic [7:0] a);
    wr_hit = b.we && (b.addr == a);
  endfunction : wr_hit

  // source control words; a request in the cycle of its ack wins
  always_comb begin
    ctrl_d = ctrl_q;
    for (int i = 0; i < ivtm_pkg::NSRC; i++) begin
      if (wr_ctrl && bus.addr == 8'(i)) begin
        ctrl_d[i] = bus.wdata[7:0];
      end
      if (ack_int && off_src_q == i[ivtm_pkg::IDXW-1:0]) begin
        ctrl_d[i].ir = 1'b0;
      end
      if (src_req[i]) begin
        ctrl_d[i].ir = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= {ivtm_pkg::NSRC{ivtm_pkg::CTRL_RESET}};
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // trap flags, software clears by writing ones
  always_comb begin
    tflag_d = tflag_q;
    if (wr_hit(bus, ivtm_pkg::ADDR_TRAP_FLAG)) begin
      tflag_d = tflag_q & ~bus.wdata[7:0];
    end
    // a new trap in the cycle of the clear is kept
    tflag_d = tflag_d | trap_evt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tflag_q <= ivtm_pkg::TF_RESET;
    end else begin
      tflag_q <= tflag_d;
    end
  end

  // pending traps, dropped when their offer is taken
  always_comb begin
    tpend_d = tpend_q;
    if (ack_trap) begin
      tpend_d = tpend_q & ~off_sel_q;
    end
    tpend_d = tpend_d | trap_evt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tpend_q <= '0;
    end else begin
      tpend_q <= tpend_d;
    end
  end

  // service nesting, the inner class a service ends first
  always_comb begin
    busy_a_d = busy_a_q;
    busy_b_d = busy_b_q;
    if (trap_done) begin
      if (busy_a_q) begin
        busy_a_d = 1'b0;
      end else begin
        busy_b_d = 1'b0;
      end
    end
    if (ack_trap) begin
      if (off_cls_a_q) begin
        busy_a_d = 1'b1;
      end else begin
        busy_b_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_a_q <= 1'b0;
      busy_b_q <= 1'b0;
    end else begin
      busy_a_q <= busy_a_d;
      busy_b_q <= busy_b_d;
    end
  end

  // vector offer to the cpu
  always_comb begin
    vec_valid_d   = 1'b0;
    vec_is_trap_d = 1'b0;
    vec_num_d     = 7'h00;
    off_cls_a_d   = 1'b0;
    off_sel_d     = '0;
    off_src_d     = '0;
    // the offer drops for one cycle after each ack
    if (!vec_ack) begin
      if (tr_valid) begin
        vec_valid_d   = 1'b1;
        vec_is_trap_d = 1'b1;
        vec_num_d     = tr_num;
        off_cls_a_d   = tr_cls_a;
        off_sel_d     = tr_sel;
      end else if (win_valid && win_lvl > cpu_level && !busy_a_q && !busy_b_q) begin
        vec_valid_d = 1'b1;
        vec_num_d   = ivtm_pkg::ivtm_trap_num(win_idx);
        off_src_d   = win_idx;
      end
    end
    vec_addr_d = vec_valid_d ? ivtm_pkg::ivtm_vec_addr(vec_num_d) : 16'h0000;
    xfer_ok_d  = !busy_a_d && !busy_b_d;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vec_valid_q   <= 1'b0;
      vec_is_trap_q <= 1'b0;
      vec_num_q     <= 7'h00;
      vec_addr_q    <= 16'h0000;
      off_cls_a_q   <= 1'b0;
      off_sel_q     <= '0;
      off_src_q     <= '0;
      xfer_ok_q     <= 1'b1;
    end else begin
      vec_valid_q   <= vec_valid_d;
      vec_is_trap_q <= vec_is_trap_d;
      vec_num_q     <= vec_num_d;
      vec_addr_q    <= vec_addr_d;
      off_cls_a_q   <= off_cls_a_d;
      off_sel_q     <= off_sel_d;
      off_src_q     <= off_src_d;
      xfer_ok_q     <= xfer_ok_d;
    end
  end

  // sticky event status, a take in the cycle of the clear is kept
  always_comb begin
    ev_st_d = ev_st_q;
    if (wr_hit(bus, ivtm_pkg::ADDR_EV_CLEAR)) begin
      ev_st_d = ev_st_q & ~bus.wdata[ivtm_pkg::EVW-1:0];
    end
    ev_st_d[ivtm_pkg::EV_TRAP_TAKEN] = ev_st_d[ivtm_pkg::EV_TRAP_TAKEN] | ack_trap;
    ev_st_d[ivtm_pkg::EV_INT_TAKEN]  = ev_st_d[ivtm_pkg::EV_INT_TAKEN] | ack_int;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ev_st_q <= '0;
    end else begin
      ev_st_q <= ev_st_d;
    end
  end

  // event enable and level interrupt line
  always_comb begin
    ev_en_d = ev_en_q;
    if (wr_hit(bus, ivtm_pkg::ADDR_EV_ENABLE)) begin
      ev_en_d = bus.wdata[ivtm_pkg::EVW-1:0];
    end
    irq_d = |(ev_st_d & ev_en_d);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ev_en_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      ev_en_q <= ev_en_d;
      irq_q   <= irq_d;
    end
  end

  // read port, data in the cycle after the strobe only
  always_comb begin
    rdata_d = 16'h0000;
    if (bus.re) begin
      if (bus.addr <= ivtm_pkg::ADDR_CTRL_LAST) begin
        rdata_d = {8'h00, ctrl_q[bus.addr[ivtm_pkg::IDXW-1:0]]};
      end else begin
        unique case (bus.addr)
          ivtm_pkg::ADDR_TRAP_FLAG: rdata_d = {8'h00, tflag_q};
          ivtm_pkg::ADDR_EV_STATUS: rdata_d = {14'h0000, ev_st_q};
          ivtm_pkg::ADDR_EV_ENABLE: rdata_d = {14'h0000, ev_en_q};
          ivtm_pkg::ADDR_SVC_STATE: rdata_d = {14'h0000, busy_a_q, busy_b_q};
          default:                  rdata_d = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : ivtm_core

/* ivtm_core_assertions.sv */
`timescale 1ns/1ps
module ivtm_chk (
  input logic                clk,
  input logic                reset,
  input ivtm_pkg::ivtm_bus_s bus,
  input logic [15:0]         rdata_q,
  input logic [7:0]          trap_evt,
  input logic                vec_ack,
  input logic                vec_valid_q,
  input logic                vec_is_trap_q,
  input logic [6:0]          vec_num_q,
  input logic [15:0]         vec_addr_q,
  input logic                xfer_ok_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence trap_seen;
    trap_evt != 8'h00 && xfer_ok_q && !vec_ack ##1 !vec_ack;
  endsequence
  addr_num_a: assert property (vec_addr_q == {7'h00, vec_num_q, 2'b00})
    else $error("vector address mismatch");
  idle_zero_a: assert property (!vec_valid_q |-> vec_addr_q == 16'h0000)
    else $error("address without offer");
  trap_now_a: assert property (trap_seen |=> vec_valid_q && vec_is_trap_q)
    else $error("trap not offered");
  trap_num_a: assert property (
    vec_valid_q && vec_is_trap_q |-> vec_num_q inside {7'h02, 7'h04, 7'h06, 7'h0a})
    else $error("bad trap number");
  trap_busy_a: assert property (vec_ack && vec_is_trap_q |=> !xfer_ok_q)
    else $error("transfer allowed in trap");
  no_int_a: assert property (!xfer_ok_q |-> !vec_valid_q || vec_is_trap_q)
    else $error("interrupt offered in trap");
  ack_drop_a: assert property (vec_ack |=> !vec_valid_q)
    else $error("offer kept after ack");
  rd_upper_a: assert property (
    $past(bus.re) && $past(bus.addr) <= ivtm_pkg::ADDR_CTRL_LAST |-> rdata_q[15:8] == 8'h00)
    else $error("upper byte not zero");
  cover property (vec_ack && vec_is_trap_q);
  cover property (vec_ack && vec_is_trap_q && !xfer_ok_q);
  cover property (vec_ack && !vec_is_trap_q);
  cover property (bus.we ##2 bus.re);
endmodule : ivtm_chk

bind ivtm_core ivtm_chk u_chk (
  .clk(clk), .reset(reset), .bus(bus), .rdata_q(rdata_q), .trap_evt(trap_evt),
  .vec_ack(vec_ack), .vec_valid_q(vec_valid_q), .vec_is_trap_q(vec_is_trap_q),
  .vec_num_q(vec_num_q), .vec_addr_q(vec_addr_q), .xfer_ok_q(xfer_ok_q));

/* ivtm_cpu_model.sv */
`timescale 1ns/1ps
module ivtm_cpu_model (
  input  logic        clk,
  input  logic        reset,
  input  logic        vec_valid_q,
  input  logic        vec_is_trap_q,
  input  logic [15:0] vec_addr_q,
  input  logic [3:0]  ack_lag,
  input  logic [3:0]  done_lag,
  output logic        vec_ack,
  output logic        trap_done,
  output logic        taken,
  output logic        taken_trap,
  output logic [15:0] taken_addr
);
  int   wait_n;
  int   done_n;
  int   depth;
  logic fin;
  // nested trap services end one at a time
  assign fin = depth > 0 && done_n >= int'(done_lag);
  always_ff @(posedge clk) begin
    if (reset) begin
      vec_ack    <= 1'b0;
      trap_done  <= 1'b0;
      taken      <= 1'b0;
      taken_trap <= 1'b0;
      taken_addr <= 16'h0000;
      wait_n     <= 0;
      done_n     <= 0;
      depth      <= 0;
    end else begin
      vec_ack   <= vec_valid_q && !vec_ack && wait_n >= int'(ack_lag);
      wait_n    <= (vec_valid_q && !vec_ack) ? wait_n + 1 : 0;
      taken     <= vec_ack;
      trap_done <= fin;
      done_n    <= (fin || depth == 0) ? 0 : done_n + 1;
      depth     <= depth + int'(vec_ack && vec_is_trap_q) - int'(fin);
      if (vec_ack) begin
        taken_trap <= vec_is_trap_q;
        taken_addr <= vec_addr_q;
      end
    end
  end
endmodule : ivtm_cpu_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic                clk;
  logic                reset;
  ivtm_pkg::ivtm_bus_s bus;
  logic [15:0]         rdata_q;
  logic [55:0]         src_req;
  logic [7:0]          trap_evt;
  logic [3:0]          cpu_level;
  logic                vec_ack;
  logic                trap_done;
  logic                vec_valid_q;
  logic                vec_is_trap_q;
  logic [15:0]         vec_addr_q;
  logic                xfer_ok_q;
  logic                irq_q;
  logic [3:0]          ack_lag;
  logic [3:0]          done_lag;
  logic                taken;
  logic                taken_trap;
  logic [15:0]         taken_addr;
  int                  n_fail;
  int                  cmp_count;
  // source index beside its trap number
  logic [12:0]         rows [16] = '{
    {6'h00, 7'h10}, {6'h0f, 7'h1f}, {6'h10, 7'h30}, {6'h1c, 7'h3c}, {6'h1d, 7'h44},
    {6'h1f, 7'h46}, {6'h20, 7'h20}, {6'h21, 7'h21}, {6'h22, 7'h22}, {6'h26, 7'h26},
    {6'h28, 7'h28}, {6'h29, 7'h29}, {6'h30, 7'h3d}, {6'h33, 7'h40}, {6'h36, 7'h43},
    {6'h37, 7'h47}};

  ivtm_core dut (
    .clk(clk), .reset(reset), .bus(bus), .rdata_q(rdata_q), .src_req(src_req),
    .trap_evt(trap_evt), .cpu_level(cpu_level), .vec_ack(vec_ack), .trap_done(trap_done),
    .vec_valid_q(vec_valid_q), .vec_is_trap_q(vec_is_trap_q), .vec_num_q(),
    .vec_addr_q(vec_addr_q), .xfer_ok_q(xfer_ok_q), .irq_q(irq_q));
  ivtm_cpu_model cpu (
    .clk(clk), .reset(reset), .vec_valid_q(vec_valid_q), .vec_is_trap_q(vec_is_trap_q),
    .vec_addr_q(vec_addr_q), .ack_lag(ack_lag), .done_lag(done_lag), .vec_ack(vec_ack),
    .trap_done(trap_done), .taken(taken), .taken_trap(taken_trap), .taken_addr(taken_addr));

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(string what, logic [7:0] a, logic [15:0] exp);
    @(posedge clk);
    bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(what, exp, rdata_q);
  endtask : rd

  task automatic req(logic [55:0] s, logic [7:0] t);
    @(posedge clk);
    src_req  <= s;
    trap_evt <= t;
    @(posedge clk);
    src_req  <= '0;
    trap_evt <= '0;
  endtask : req

  task automatic take(logic [6:0] num, logic trap);
    int i;
    // step past a take pulse that the previous call has already seen
    @(negedge clk);
    for (i = 0; i < 80 && taken !== 1'b1; i++) @(negedge clk);
    chk("vector", {1'b1, 5'h00, trap, num, 2'b00}, {taken, 5'h00, taken_trap, taken_addr[8:0]});
  endtask : take

  task automatic quiet();
    int i;
    int k;
    k = 0;
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      k += int'(taken === 1'b1);
    end
    chk("quiet", 16'h0000, 16'(k));
  endtask : quiet

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // about thirty times the expected run
  initial begin
    #800000;
    n_fail++;
    complete_run();
  end

  initial begin
    int i;
    reset     = 1'b1;
    bus       = '0;
    src_req   = '0;
    trap_evt  = '0;
    cpu_level = 4'h0;
    ack_lag   = 4'h0;
    done_lag  = 4'h4;
    n_fail    = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 16; i++) begin
      wr({2'b00, rows[i][12:7]}, 16'hff44);
      req(56'h1 << rows[i][12:7], 8'h00);
      take(rows[i][6:0], 1'b0);
    end
    rd("ctrl", 8'h37, 16'h0044);
    wr(8'h02, 16'h0004);
    req(56'h4, 8'h00);
    quiet();
    rd("ctrl", 8'h02, 16'h0084);
    wr(8'h02, 16'h00c4);
    take(7'h12, 1'b0);
    wr(8'h03, 16'h0054);
    wr(8'h04, 16'h0057);
    req(56'h18, 8'h00);
    take(7'h14, 1'b0);
    take(7'h13, 1'b0);
    wr(8'h06, 16'h007c);
    wr(8'h07, 16'h007b);
    req(56'hc0, 8'h00);
    take(7'h16, 1'b0);
    take(7'h17, 1'b0);
    @(posedge clk);
    cpu_level <= 4'h5;
    wr(8'h08, 16'h0054);
    req(56'h100, 8'h00);
    quiet();
    @(posedge clk);
    cpu_level <= 4'h0;
    take(7'h18, 1'b0);
    ack_lag  <= 4'h3;
    done_lag <= 4'hf;
    wr(8'h09, 16'h0044);
    req(56'h200, 8'h08);
    take(7'h0a, 1'b1);
    chk("xfer", 16'h0000, 16'(xfer_ok_q));
    rd("svc", ivtm_pkg::ADDR_SVC_STATE, 16'h0001);
    req(56'h0, 8'h01);
    take(7'h02, 1'b1);
    rd("svc", ivtm_pkg::ADDR_SVC_STATE, 16'h0003);
    take(7'h19, 1'b0);
    rd("trapflag", ivtm_pkg::ADDR_TRAP_FLAG, 16'h0009);
    wr(ivtm_pkg::ADDR_TRAP_FLAG, 16'h0009);
    rd("trapflag", ivtm_pkg::ADDR_TRAP_FLAG, 16'h0000);
    rd("status", ivtm_pkg::ADDR_EV_STATUS, 16'h0003);
    chk("irq", 16'h0000, 16'(irq_q));
    wr(ivtm_pkg::ADDR_EV_ENABLE, 16'h0001);
    rd("unmapped", 8'h50, 16'h0000);
    chk("irq", 16'h0001, 16'(irq_q));
    wr(ivtm_pkg::ADDR_EV_CLEAR, 16'h0003);
    rd("status", ivtm_pkg::ADDR_EV_STATUS, 16'h0000);
    chk("irq", 16'h0000, 16'(irq_q));
    wr(8'h05, 16'h0004);
    req(56'h20, 8'h80);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("xfer", 16'h0001, 16'(xfer_ok_q));
    rd("ctrl", 8'h05, 16'h0000);
    rd("trapflag", ivtm_pkg::ADDR_TRAP_FLAG, 16'h0000);
    complete_run();
  end
endmodule : tb_top
